// ---- logic/dih_hold_timer.sv ----
// Bus tenure timer for cycle steal with hold, one for all channels
// Assumes transfer and request strobes come from the same clock
`timescale 1ns/1ps
`include "dih_map.svh"

module dih_hold_timer (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [1:0] burst_time_i,
   input  wire logic [1:0] bandwidth_i,
   input  wire logic       hold_mode_i,
   input  wire logic       xfer_i,
   input  wire logic       dreq_i,
   output logic            bus_hold_o,
   output logic            release_o
);
   localparam int SYS_HZ  = `DIH_SYS_CLK_HZ;
   localparam int CORE_HZ = `DIH_CORE_CLK_HZ;
   // Core ticks are spread over the system clock by a fraction adder
   localparam int TICK_NUM = CORE_HZ / 1000000;
   localparam int TICK_DEN = SYS_HZ / 1000000;

   logic [6:0]  acc_r;
   logic [6:0]  acc_sum;
   logic        tick;
   logic [3:0]  exp_sum;
   logic [11:0] interval;
   logic [11:0] elapsed_r;
   logic        seen_req_r;
   logic        own_r;
   logic        expire;

   assign acc_sum  = acc_r + 7'(TICK_NUM);
   assign tick     = acc_sum >= 7'(TICK_DEN);
   assign exp_sum  = 4'(burst_time_i) + 4'(bandwidth_i)
                   + 4'(`DIH_HOLD_EXP_BASE);
   assign interval = 12'h001 << exp_sum;  // see RL10
   // First tick after a transfer is partial, so one more tick is counted
   // to make sure a whole interval has passed before the bus goes
   assign expire   = own_r && !seen_req_r && tick
                   && elapsed_r >= interval;  // see RL9

   always_ff @(posedge clk_i) begin
      if (reset_i)
         acc_r <= 7'h00;
      else
         acc_r <= tick ? 7'(acc_sum - 7'(TICK_DEN)) : acc_sum;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         own_r      <= 1'b0;
         seen_req_r <= 1'b0;
         elapsed_r  <= 12'h000;
         release_o  <= 1'b0;
      end else begin
         release_o <= 1'b0;
         if (xfer_i) begin
            own_r      <= hold_mode_i;  // see RL8
            release_o  <= !hold_mode_i;
            seen_req_r <= 1'b0;
            elapsed_r  <= 12'h000;
         end else if (own_r && dreq_i) begin
            seen_req_r <= 1'b1;  // see RL8
         end else if (expire) begin
            own_r     <= 1'b0;
            release_o <= 1'b1;
         end else if (own_r && tick) begin
            elapsed_r <= elapsed_r + 12'h001;
         end
      end
   end

   assign bus_hold_o = own_r;

   AST_HOLD_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
      own_r && dreq_i && !xfer_i |=> own_r) // see RL8
      else $error("Bus given up while a request was pending");

   AST_HOLD_FULL_INTERVAL: assert property (@(posedge clk_i)
      disable iff (reset_i)
      own_r && !xfer_i ##1 release_o
         |-> $past(elapsed_r) >= $past(interval)) // see RL9
      else $error("Hold released before a full sample interval");

   AST_TICK_RATE: assert property (@(posedge clk_i) disable iff (reset_i)
      tick |=> !tick) // see RL10
      else $error("Core tick ran faster than the core clock");
endmodule : dih_hold_timer

// ---- logic/dih_irq_arbiter.sv ----
// Picks the channel to vector: highest priority, round-robin on ties
// Assumes requests and priorities come from logic on the same clock
`timescale 1ns/1ps
`include "dih_map.svh"

module dih_irq_arbiter #(
   parameter int NUM_CH = 4
) (
   input  wire logic                      clk_i,
   input  wire logic                      reset_i,
   input  wire logic [NUM_CH-1:0]         req_i,
   input  wire logic [2*NUM_CH-1:0]       prio_i,
   input  wire logic                      advance_i,
   output logic                           any_o,
   output logic [$clog2(NUM_CH)-1:0]      win_o
);
   localparam int IW = $clog2(NUM_CH);

   if (NUM_CH < 2 || (1 << IW) != NUM_CH) begin : g_bad_num_ch
      $error("dih_irq_arbiter: NUM_CH must be a power of two");
   end

   logic [IW-1:0] last_r;
   logic [1:0]    top_prio;
   logic [IW-1:0] idx;
   logic          found;

   // Search starts just past the last winner so equal levels rotate
   always_comb begin
      top_prio = 2'h0;
      found    = 1'b0;
      win_o    = last_r;
      idx      = last_r;
      for (int i = 0; i < NUM_CH; i++) begin
         if (req_i[i] && prio_i[2*i +: 2] >= top_prio)
            top_prio = prio_i[2*i +: 2];
      end
      for (int k = 1; k <= NUM_CH; k++) begin
         idx = IW'(last_r + IW'(k));
         if (!found && req_i[idx] && prio_i[2*idx +: 2] == top_prio) begin
            found = 1'b1;
            win_o = idx;
         end
      end
   end  // see RL25

   assign any_o = |req_i;

   always_ff @(posedge clk_i) begin
      if (reset_i)
         last_r <= IW'(NUM_CH - 1);
      else if (advance_i && any_o)
         last_r <= win_o;
   end

   AST_ARB_PRIO: assert property (@(posedge clk_i) disable iff (reset_i)
      any_o |-> req_i[win_o]
         && prio_i[2*win_o +: 2] == top_prio) // see RL25
      else $error("Arbiter picked a channel below the top level");
endmodule : dih_irq_arbiter

// ---- logic/dih_map.svh ----
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by the package and by every design module
`ifndef DIH_MAP_SVH
`define DIH_MAP_SVH

`define DIH_ADDR_W        10
`define DIH_HOLD_OFS      10'h0ff
`define DIH_CFGA_OFS      10'h101
`define DIH_CFGB_OFS      10'h301
`define DIH_PAGE_OFS      10'h0fd
`define DIH_NVEC_BASE     10'h040
`define DIH_FVEC_BASE     10'h048

`define DIH_IRQ_MSB       7
`define DIH_IRQ_LSB       5
`define DIH_PAIR_MSB      4
`define DIH_PAIR_LSB      3
`define DIH_CARRY_BIT     2
`define DIH_YIELD_BIT     1
`define DIH_DIR_BIT       0
`define DIH_BST_MSB       3
`define DIH_BST_LSB       2
`define DIH_BW_MSB        1
`define DIH_BW_LSB        0

`define DIH_VEC_RST       8'h0f
`define DIH_IRQ_RST       3'h0
`define DIH_PAIR_RST      2'h0
`define DIH_YIELD_RST     1'b1
`define DIH_CARRY_RST     1'b0
`define DIH_DIR_RST       1'b0
`define DIH_HOLD_RST      4'h0
`define DIH_PAGE_RST      8'h00

`define DIH_SYS_CLK_HZ    50000000
`define DIH_CORE_CLK_HZ   8000000
`define DIH_HOLD_EXP_BASE 5

`endif

// ---- logic/dih_pkg.sv ----
// Shared types for the interrupt vectoring and bus hold block
// Assumes the map header sits in the include path
`include "dih_map.svh"

package dih_pkg;
   typedef logic [7:0] dih_byte_t;
   typedef enum logic [1:0] {
      ACK_IDLE,
      ACK_DRIVE,
      ACK_WAIT_END
   } dih_ack_state_t;
endpackage : dih_pkg

// ---- logic/dih_top.sv ----
// Interrupt vectoring, hold timing and first configuration register
// Assumes the register strobes are synchronous to clk_i, while the
// acknowledge and GPIB status pins arrive from outside and are synced.
// Notes on behaviour
// RL1: Two eight-bit vector registers per channel
// RL2: Answer acknowledge only on matching programmed level
// RL3: Drive chosen vector on low data byte
// RL4: Request needs enable plus done, block, edge
// RL5: Software uses channel one and three for status
// RL6: Fault vector replaces normal when error set
// RL7: All vectors reset to 0x0f
// RL8: Hold mode keeps bus until partner pauses
// RL9: Pause means no request for full interval
// RL10: Interval is two to burst+bandwidth+5 ticks
// RL11: One hold-timing register shared by channels
// RL12: Burst field bits 3:2, 16 to 128
// RL13: Bandwidth field bits 1:0, 50 to 6.25%
// RL14: Hold register bits 7:4 read zero
// RL15: Shared bits single copy, port bits separate
// RL16: Config address reads GPIB status, writes config
// RL17: Shared page register drives A31 to A24
// RL18: Config one at 101 and 301 hex
// RL19: Line field 001 to 101 picks IRQ1-5
// RL20: 110, 111 pick IRQ6, IRQ7; reset none
// RL21: Bus pair field bits 4:3, reset pair 0
// RL22: Yield bit 1 disables, resets to 1
// RL23: Direction bit per port, resets to 0
// RL24: Request drops once enable or causes clear
// RL25: Highest priority first, round-robin on ties
`timescale 1ns/1ps
`include "dih_map.svh"

module dih_top #(
   parameter int NUM_CH = 4
) (
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   input  wire logic [9:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [7:0]                 reg_rdata_o,
   input  wire logic [7:0]            gpib_status_a_i,
   input  wire logic [7:0]            gpib_status_b_i,
   input  wire logic [NUM_CH-1:0]     irq_enable_bit_i,
   input  wire logic [NUM_CH-1:0]     channel_done_flag_i,
   input  wire logic [NUM_CH-1:0]     block_done_flag_i,
   input  wire logic [NUM_CH-1:0]     peripheral_edge_flag_i,
   input  wire logic [NUM_CH-1:0]     peripheral_line_irq_i,
   input  wire logic [NUM_CH-1:0]     error_flag_i,
   input  wire logic [2*NUM_CH-1:0]   priority_i,
   input  wire logic                  iack_n_i,
   input  wire logic [2:0]            iack_level_i,
   output logic [6:0]                 irq_line_o,
   output logic [7:0]                 iack_data_o,
   output logic                       iack_data_oe_o,
   output logic                       iack_done_o,
   output logic [NUM_CH-1:0]          iack_chan_o,
   input  wire logic [NUM_CH-1:0]     hold_mode_i,
   input  wire logic [NUM_CH-1:0]     xfer_i,
   input  wire logic [NUM_CH-1:0]     dreq_i,
   output logic                       bus_hold_o,
   output logic                       bus_release_o,
   output logic [2:0]                 irq_line_select_o,
   output logic [1:0]                 bus_pair_select_o,
   output logic                       yield_on_request_o,
   output logic [1:0]                 carry_enable_o,
   output logic [1:0]                 direction_o,
   input  wire logic                  ext_addr_i,
   output logic [7:0]                 addr_hi_o
);
   localparam int IW = $clog2(NUM_CH);

   if (NUM_CH != 4) begin : g_bad_num_ch
      $error("dih_top: hold register and decode serve four channels");
   end

   function automatic logic hit(input logic [9:0] addr,
                                input logic [9:0] ofs);
      hit = addr == ofs;
   endfunction : hit

   // Pin synchronisers: first stage feeds only the second
   logic [11:0] iack_meta_r;
   logic [11:0] iack_sync_r;
   logic [15:0] stat_meta_r;
   logic [15:0] stat_sync_r;
   logic        iack_s;
   logic [2:0]  iack_lvl_s;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         iack_meta_r <= 12'h001;
         iack_sync_r <= 12'h001;
         stat_meta_r <= 16'h0000;
         stat_sync_r <= 16'h0000;
      end else begin
         iack_meta_r <= {8'h00, iack_level_i, iack_n_i};
         iack_sync_r <= iack_meta_r;
         stat_meta_r <= {gpib_status_b_i, gpib_status_a_i};
         stat_sync_r <= stat_meta_r;
      end
   end

   assign iack_s     = !iack_sync_r[0];
   assign iack_lvl_s = iack_sync_r[3:1];

   // Register decode
   logic wr_hold;
   logic wr_cfg_a;
   logic wr_cfg_b;
   logic wr_cfg;
   logic wr_page;

   assign wr_hold  = reg_wr_i && hit(reg_addr_i, `DIH_HOLD_OFS);
   assign wr_cfg_a = reg_wr_i && hit(reg_addr_i, `DIH_CFGA_OFS);  // see RL18
   assign wr_cfg_b = reg_wr_i && hit(reg_addr_i, `DIH_CFGB_OFS);  // see RL18
   assign wr_cfg   = wr_cfg_a || wr_cfg_b;
   assign wr_page  = reg_wr_i && hit(reg_addr_i, `DIH_PAGE_OFS);

   // Vector storage, one pair per channel
   dih_pkg::dih_byte_t nvec_r [NUM_CH];
   dih_pkg::dih_byte_t fvec_r [NUM_CH];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_vec
      logic wr_n;
      logic wr_f;
      assign wr_n = reg_wr_i
                  && hit(reg_addr_i, `DIH_NVEC_BASE + 10'(c));  // see RL1
      assign wr_f = reg_wr_i
                  && hit(reg_addr_i, `DIH_FVEC_BASE + 10'(c));  // see RL1
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            nvec_r[c] <= `DIH_VEC_RST;  // see RL7
            fvec_r[c] <= `DIH_VEC_RST;  // see RL7
         end else begin
            if (wr_n)
               nvec_r[c] <= reg_wdata_i;
            if (wr_f)
               fvec_r[c] <= reg_wdata_i;
         end
      end
   end

   // Shared and per-port configuration, hold timing and page
   logic [3:0] hold_timing_r;
   logic [2:0] irq_sel_r;
   logic [1:0] pair_sel_r;
   logic       yield_r;
   logic [1:0] carry_r;
   logic [1:0] dir_r;
   logic [7:0] page_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hold_timing_r <= `DIH_HOLD_RST;
         irq_sel_r     <= `DIH_IRQ_RST;  // see RL20
         pair_sel_r    <= `DIH_PAIR_RST;  // see RL21
         yield_r       <= `DIH_YIELD_RST;  // see RL22
         page_r        <= `DIH_PAGE_RST;
      end else begin
         if (wr_hold)
            hold_timing_r <= reg_wdata_i[3:0];  // see RL11
         // Either port's write lands in the single shared copy
         if (wr_cfg) begin
            irq_sel_r  <= reg_wdata_i[`DIH_IRQ_MSB:`DIH_IRQ_LSB];  // see RL15
            pair_sel_r <= reg_wdata_i[`DIH_PAIR_MSB:`DIH_PAIR_LSB];  // see RL21
            yield_r    <= reg_wdata_i[`DIH_YIELD_BIT];  // see RL22
         end
         if (wr_page)
            page_r <= reg_wdata_i;  // see RL17
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_port
      logic wr_p;
      assign wr_p = (p == 0) ? wr_cfg_a : wr_cfg_b;
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            carry_r[p] <= `DIH_CARRY_RST;
            dir_r[p]   <= `DIH_DIR_RST;  // see RL23
         end else if (wr_p) begin
            carry_r[p] <= reg_wdata_i[`DIH_CARRY_BIT];  // see RL15
            dir_r[p]   <= reg_wdata_i[`DIH_DIR_BIT];  // see RL23
         end
      end
   end

   assign irq_line_select_o  = irq_sel_r;
   assign bus_pair_select_o  = pair_sel_r;
   assign yield_on_request_o = yield_r;
   assign carry_enable_o     = carry_r;
   assign direction_o        = dir_r;
   assign addr_hi_o          = ext_addr_i ? page_r : 8'h00;  // see RL17

   // Read path; the config address answers with GPIB line status
   logic [7:0] rd_mux;
   logic [7:0] vec_rd;

   always_comb begin
      vec_rd = 8'h00;
      for (int c = 0; c < NUM_CH; c++) begin
         if (hit(reg_addr_i, `DIH_NVEC_BASE + 10'(c)))
            vec_rd = nvec_r[c];
         if (hit(reg_addr_i, `DIH_FVEC_BASE + 10'(c)))
            vec_rd = fvec_r[c];
      end
   end

   assign rd_mux =
      hit(reg_addr_i, `DIH_HOLD_OFS)  ? {4'h0, hold_timing_r} :  // see RL14
      hit(reg_addr_i, `DIH_CFGA_OFS)  ? stat_sync_r[7:0] :  // see RL16
      hit(reg_addr_i, `DIH_CFGB_OFS)  ? stat_sync_r[15:8] :  // see RL16
      hit(reg_addr_i, `DIH_PAGE_OFS)  ? page_r : vec_rd;

   always_ff @(posedge clk_i) begin
      if (reset_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= rd_mux;
   end

   // Interrupt requests; level follows the flags with no latching
   logic [NUM_CH-1:0] ch_req;
   logic              any_req;
   logic [IW-1:0]     win;
   logic              grant;
   logic [7:0]        sel_vec;
   logic [6:0]        line_dec;

   assign ch_req = irq_enable_bit_i & (channel_done_flag_i
                 | block_done_flag_i
                 | (peripheral_edge_flag_i & peripheral_line_irq_i));  // see RL4
   assign line_dec = (irq_sel_r == 3'h0) ? 7'h00
                   : 7'(7'h01 << (irq_sel_r - 3'h1));  // see RL19

   always_ff @(posedge clk_i) begin
      if (reset_i)
         irq_line_o <= 7'h00;
      else
         irq_line_o <= (|ch_req) ? line_dec : 7'h00;  // see RL24
   end

   dih_irq_arbiter #(
      .NUM_CH (NUM_CH)
   ) u_arb (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .req_i     (ch_req),
      .prio_i    (priority_i),
      .advance_i (grant),
      .any_o     (any_req),
      .win_o     (win)
   );

   assign sel_vec = error_flag_i[win] ? fvec_r[win] : nvec_r[win];  // see RL6

   // Acknowledge cycle
   dih_pkg::dih_ack_state_t ack_r;
   dih_pkg::dih_ack_state_t ack_nxt;

   assign grant = ack_r == dih_pkg::ACK_IDLE && iack_s && any_req
                && irq_sel_r != 3'h0 && iack_lvl_s == irq_sel_r;  // see RL2

   always_comb begin
      case (ack_r)
         dih_pkg::ACK_IDLE:     ack_nxt = grant ? dih_pkg::ACK_DRIVE
                                                : dih_pkg::ACK_IDLE;
         dih_pkg::ACK_DRIVE:    ack_nxt = iack_s ? dih_pkg::ACK_DRIVE
                                                 : dih_pkg::ACK_WAIT_END;
         dih_pkg::ACK_WAIT_END: ack_nxt = dih_pkg::ACK_IDLE;
         default:               ack_nxt = dih_pkg::ACK_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_r       <= dih_pkg::ACK_IDLE;
         iack_data_o <= 8'h00;
         iack_chan_o <= '0;
      end else begin
         ack_r       <= ack_nxt;
         iack_chan_o <= '0;
         if (grant) begin
            iack_data_o      <= sel_vec;  // see RL3
            iack_chan_o[win] <= 1'b1;
         end
      end
   end

   assign iack_data_oe_o = ack_r == dih_pkg::ACK_DRIVE;  // see RL3
   assign iack_done_o    = ack_r == dih_pkg::ACK_DRIVE;

   // Hold timing, one timer for all channels
   dih_hold_timer u_hold (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .burst_time_i (hold_timing_r[`DIH_BST_MSB:`DIH_BST_LSB]),  // see RL12
      .bandwidth_i  (hold_timing_r[`DIH_BW_MSB:`DIH_BW_LSB]),  // see RL13
      .hold_mode_i  (|(hold_mode_i & xfer_i)),
      .xfer_i       (|xfer_i),
      .dreq_i       (|dreq_i),
      .bus_hold_o   (bus_hold_o),
      .release_o    (bus_release_o)
   );

   sequence s_ack_start;
      $rose(iack_data_oe_o);
   endsequence

   sequence s_ack_level_ok;
      $past(iack_lvl_s) == irq_sel_r && irq_sel_r != 3'h0;
   endsequence

   AST_ACK_LEVEL: assert property (@(posedge clk_i) disable iff (reset_i)
      s_ack_start |-> s_ack_level_ok or $past(wr_cfg)) // see RL2
      else $error("Acknowledge answered at a foreign level");

   AST_ACK_VECTOR: assert property (@(posedge clk_i) disable iff (reset_i)
      s_ack_start |-> iack_data_o == $past(sel_vec)) // see RL6
      else $error("Wrong vector returned in acknowledge");

   AST_ACK_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
      iack_data_oe_o && iack_s |=> iack_data_oe_o
         && $stable(iack_data_o)) // see RL3
      else $error("Vector dropped before acknowledge ended");

   AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (reset_i)
      ##1 |irq_line_o |-> $past(|ch_req)
         && irq_line_o == $past(line_dec)) // see RL4
      else $error("Request line raised without a cause");

   AST_IRQ_DROP: assert property (@(posedge clk_i) disable iff (reset_i)
      !(|ch_req) |=> irq_line_o == 7'h00) // see RL24
      else $error("Request line held after causes cleared");

   AST_LINE_MAP: assert property (@(posedge clk_i) disable iff (reset_i)
      irq_sel_r == 3'h7 |-> line_dec == 7'h40) // see RL20
      else $error("Line field 111 does not select IRQ7");

   AST_CFG_RESET: assert property (@(posedge clk_i)
      $fell(reset_i) |-> irq_sel_r == 3'h0 && pair_sel_r == 2'h0
         && yield_r && dir_r == 2'h0 && nvec_r[0] == 8'h0f
         && fvec_r[NUM_CH-1] == 8'h0f) // see RL7
      else $error("Configuration not at reset values");

   AST_PORT_SPLIT: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_cfg_b |=> dir_r[1] == $past(reg_wdata_i[0]) && $stable(dir_r[0])
         && irq_sel_r == $past(reg_wdata_i[7:5])) // see RL15
      else $error("Port B write leaked into port A storage");

   AST_STATUS_READ: assert property (@(posedge clk_i) disable iff (reset_i)
      reg_rd_i && hit(reg_addr_i, `DIH_CFGA_OFS)
         |=> reg_rdata_o == $past(stat_sync_r[7:0])) // see RL16
      else $error("Config address did not return GPIB status");

   AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
      reg_rd_i && hit(reg_addr_i, `DIH_HOLD_OFS)
         |=> reg_rdata_o[7:4] == 4'h0) // see RL14
      else $error("Reserved hold bits read non-zero");

   AST_PAGE_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
      ext_addr_i |-> addr_hi_o == page_r) // see RL17
      else $error("Page register not on the high address lines");
endmodule : dih_top

// ---- tb/dih_host.sv ----
// Host model: runs one acknowledge cycle per go_i pulse
// Assumes done_i and data_i are registered on clk_i
`timescale 1ns/1ps

module dih_host (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [2:0] lvl_i,
   input  wire logic       done_i,
   input  wire logic [7:0] data_i,
   output logic            iack_n_o,
   output logic [2:0]      level_o,
   output logic [7:0]      vec_o,
   output logic            got_o
);
   int n;
   initial begin
      iack_n_o = 1'b1;
      level_o = 3'h0;
      vec_o = 8'h00;
      got_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            #1 iack_n_o = 1'b0;
            level_o = lvl_i;
            got_o = 1'b0;
            n = 0;
            // A refused cycle is abandoned, as a bus timer would
            // Sample the answer once it has settled after the edge
            while (done_i !== 1'b1 && n < 20) begin
               @(posedge clk_i);
               #1;
               n++;
            end
            vec_o = data_i;
            got_o = (n < 20);
            #1 iack_n_o = 1'b1;
            level_o = ~lvl_i;
         end
      end
   end
endmodule : dih_host

// ---- tb/dih_top_tb.sv ----
// Bench for dih_top: config, vectors, interrupt lines, hold timer
// Assumes dih_host runs acknowledge cycles
`timescale 1ns/1ps
`include "dih_map.svh"

module dih_top_tb;
   logic       clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [9:0] ad = 10'h000;
   logic [7:0] wd = 8'h00, rdata, vec, dat, pr = 8'h00, ahi;
   logic [3:0] en = 4'h0, cd = 4'h0, bd = 4'h0, pe = 4'h0, pl = 4'h0;
   logic [3:0] er = 4'h0, hm = 4'h0, xf = 4'h0, dq = 4'h0;
   logic [3:0] ch, seen_ch = 4'h0;
   logic [2:0] lvl, hl = 3'h0, isel;
   logic [6:0] irq;
   logic [1:0] pair, carry, dir;
   logic       go = 1'b0, got, iack_n, oe, done, yield, hold, rel;
   logic       ext = 1'b0;
   int         fails = 0, checks = 0, n;

   dih_top dut (.clk_i, .reset_i, .reg_addr_i(ad), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .gpib_status_a_i(8'ha5), .gpib_status_b_i(8'h3c),
      .irq_enable_bit_i(en), .channel_done_flag_i(cd),
      .block_done_flag_i(bd), .peripheral_edge_flag_i(pe),
      .peripheral_line_irq_i(pl), .error_flag_i(er), .priority_i(pr),
      .iack_n_i(iack_n), .iack_level_i(lvl), .irq_line_o(irq),
      .iack_data_o(dat), .iack_data_oe_o(oe), .iack_done_o(done),
      .iack_chan_o(ch), .hold_mode_i(hm), .xfer_i(xf), .dreq_i(dq),
      .bus_hold_o(hold), .bus_release_o(rel), .irq_line_select_o(isel),
      .bus_pair_select_o(pair), .yield_on_request_o(yield),
      .carry_enable_o(carry), .direction_o(dir), .ext_addr_i(ext),
      .addr_hi_o(ahi));
   dih_host host (.clk_i, .go_i(go), .lvl_i(hl), .done_i(done),
      .data_i(dat), .iack_n_o(iack_n), .level_o(lvl), .vec_o(vec),
      .got_o(got));

   always #10 clk_i = ~clk_i;
   // Channel pulse lasts one cycle, so keep the last one seen
   always @(posedge clk_i)
      if (|ch) seen_ch <= ch;

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : step
   task automatic wreg(input logic [9:0] a, input logic [7:0] d);
      ad = a; wd = d; wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask : wreg
   task automatic rreg(input logic [9:0] a);
      ad = a; rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(1);
   endtask : rreg
   task automatic ack(input logic [2:0] l, input logic g, input logic [7:0] e,
                      input logic [3:0] c);
      hl = l; go = 1'b1;
      step(1);
      go = 1'b0;
      step(32);
      chk({7'h00, got}, {7'h00, g});
      chk({7'h00, oe}, 8'h00);
      if (g) chk(vec, e);
      if (g) chk({4'h0, seen_ch}, {4'h0, c});
   endtask : ack
   task automatic t_cfg;
      rreg(`DIH_NVEC_BASE + 10'h3); chk(rdata, 8'h0f);
      rreg(`DIH_FVEC_BASE); chk(rdata, 8'h0f);
      chk({yield, isel, pair, dir}, 8'h80);
      rreg(`DIH_HOLD_OFS); chk(rdata, 8'h00);
      wreg(`DIH_HOLD_OFS, 8'h0f);
      rreg(`DIH_HOLD_OFS); chk(rdata, 8'h0f);
      wreg(10'h101, 8'h3d);
      chk({yield, isel, pair, dir}, 8'h1d);
      rreg(10'h101); chk(rdata, 8'ha5);
      wreg(10'h301, 8'h40);
      chk({yield, isel, pair, dir}, 8'h21);
      chk({6'h00, carry}, 8'h01);
      rreg(10'h301); chk(rdata, 8'h3c);
      rreg(10'h3ff); chk(rdata, 8'h00);
      wreg(`DIH_PAGE_OFS, 8'hc3);
      ext = 1'b1; step(1); chk(ahi, 8'hc3);
      ext = 1'b0; step(1); chk(ahi, 8'h00);
   endtask : t_cfg
   task automatic t_irq;
      for (int i = 0; i < 8; i++) begin
         wreg(10'h301, {i[2:0], 5'h00});
         en = 4'h8; bd = 4'h8; step(2);
         chk({1'b0, irq}, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
         en = 4'h0; step(2); chk({1'b0, irq}, 8'h00);
         bd = 4'h0;
      end
      en = 4'h1; pe = 4'h1; step(2); chk({1'b0, irq}, 8'h00);
      pl = 4'h1; step(2); chk({1'b0, irq}, 8'h40);
      pe = 4'h0; cd = 4'h1; step(2); chk({1'b0, irq}, 8'h40);
      cd = 4'h0; step(2); chk({1'b0, irq}, 8'h00);
      en = 4'h0; pl = 4'h0;
   endtask : t_irq
   task automatic t_ack;
      wreg(10'h101, 8'h60);
      wreg(`DIH_NVEC_BASE + 10'h1, 8'h51);
      wreg(`DIH_FVEC_BASE + 10'h1, 8'h91);
      wreg(`DIH_NVEC_BASE + 10'h2, 8'h52);
      en = 4'h6; cd = 4'h2;
      ack(3'h2, 1'b0, 8'h00, 4'h0);
      ack(3'h3, 1'b1, 8'h51, 4'h2);
      er = 4'h2; ack(3'h3, 1'b1, 8'h91, 4'h2);
      cd = 4'h6; pr = 8'h30; ack(3'h3, 1'b1, 8'h52, 4'h4);
      pr = 8'h00; ack(3'h3, 1'b1, 8'h91, 4'h2);
      ack(3'h3, 1'b1, 8'h52, 4'h4);
      cd = 4'h0; en = 4'h0; er = 4'h0;
   endtask : t_ack
   task automatic t_hold;
      wreg(`DIH_HOLD_OFS, 8'h00);
      xf = 4'h1; step(1); xf = 4'h0; chk({7'h00, rel}, 8'h01);
      hm = 4'h1; xf = 4'h1; step(1); xf = 4'h0;
      chk({7'h00, hold}, 8'h01);
      for (n = 1; rel !== 1'b1 && n < 400; n++) step(1);
      chk({7'h00, n >= 200 && n <= 207}, 8'h01);
      wreg(`DIH_HOLD_OFS, 8'h05);
      dq = 4'h1; xf = 4'h1; step(1); xf = 4'h0;
      for (n = 0; rel !== 1'b1 && n < 900; n++) step(1);
      chk({7'h00, hold}, 8'h01);
      dq = 4'h0; xf = 4'h1; step(1); xf = 4'h0;
      for (n = 1; rel !== 1'b1 && n < 1000; n++) step(1);
      chk({7'h00, n >= 800 && n <= 807}, 8'h01);
      hm = 4'h0;
   endtask : t_hold
   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   initial begin
      step(2);
      reset_i = 1'b0;
      t_cfg; t_irq; t_ack; t_hold;
      report_and_stop;
   end
   initial begin
      #400000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop;
   end
endmodule : dih_top_tb
